// ===== design/uffs_pkg.sv
// Purpose: Shared constants for the receive level, trigger and flow character block.
// Assumes: Byte wide register port, one UART channel.
// Notes: Register offsets are port addresses on the byte register port.
package uffs_pkg;
   localparam int unsigned UFFS_DW = 8;
   localparam int unsigned UFFS_AW = 4;
   localparam int unsigned UFFS_FIFO_DEPTH = 64;
   localparam logic [3:0] UFFS_OFS_RX_COUNT = 4'h0;
   localparam logic [3:0] UFFS_OFS_RX_TRIG = 4'h1;
   localparam logic [3:0] UFFS_OFS_STOP1 = 4'h2;
   localparam logic [3:0] UFFS_OFS_STOP2 = 4'h3;
   localparam logic [3:0] UFFS_OFS_RESUME1 = 4'h4;
   localparam logic [3:0] UFFS_OFS_RESUME2 = 4'h5;
   localparam logic [3:0] UFFS_OFS_FLOW_STATUS = 4'h6;
   localparam logic [3:0] UFFS_OFS_FEATURE = 4'h7;
   localparam logic [3:0] UFFS_OFS_MODEM = 4'h8;
   localparam logic [1:0] UFFS_CHR_STOP1 = 2'h0;
   localparam logic [1:0] UFFS_CHR_STOP2 = 2'h1;
   localparam logic [1:0] UFFS_CHR_RESUME1 = 2'h2;
   localparam logic [1:0] UFFS_CHR_RESUME2 = 2'h3;
   localparam int unsigned UFFS_ST_TX_RESUME = 3;
   localparam int unsigned UFFS_ST_TX_STOP = 2;
   localparam int unsigned UFFS_ST_RX_RESUME = 1;
   localparam int unsigned UFFS_ST_RX_STOP = 0;
   localparam logic [7:0] UFFS_RST_BYTE = 8'h00;
   localparam logic [3:0] UFFS_FLOW_OFF = 4'h0;
   typedef enum logic [1:0] {
      UFFS_RXCMP_NONE = 2'b00,
      UFFS_RXCMP_SECOND = 2'b01,
      UFFS_RXCMP_FIRST = 2'b10,
      UFFS_RXCMP_BOTH = 2'b11
   } uffs_rxcmp_t;
endpackage

// ===== design/uffs_char_bank.sv
// Purpose: Four byte store for the stop and resume characters.
// Assumes: Same clock as the register port; one write per cycle.
// Notes: Every word is visible at once so the receive compare can use all four.
`timescale 1ns/1ps
`default_nettype none
module uffs_char_bank
   import uffs_pkg::*;
#(
   parameter int unsigned WIDTH = UFFS_DW
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [1:0] wr_sel,
   input wire logic [WIDTH-1:0] wr_data,
   output logic [WIDTH-1:0] stop_char_first,
   output logic [WIDTH-1:0] stop_char_second,
   output logic [WIDTH-1:0] resume_char_first,
   output logic [WIDTH-1:0] resume_char_second
);
   logic [WIDTH-1:0] mem [4];

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_word
         always_ff @(posedge clk) begin
            if (rst) begin
               mem[gi] <= '0; // see RULE12
            end else if (wr_en && wr_sel == 2'(gi)) begin
               mem[gi] <= wr_data; // see RULE4
            end
         end
      end
   endgenerate

   assign stop_char_first = mem[UFFS_CHR_STOP1];
   assign stop_char_second = mem[UFFS_CHR_STOP2];
   assign resume_char_first = mem[UFFS_CHR_RESUME1];
   assign resume_char_second = mem[UFFS_CHR_RESUME2];
endmodule
`default_nettype wire

// ===== design/uffs_top.sv
// Purpose: Receive fill counter, receive trigger request, flow characters and their status.
// Assumes: The FIFO, transmitter and receiver of the channel report events as one-cycle pulses.
// Notes: Registers are reached on a byte port; read data appear one cycle after the read strobe.
// Function
// RULE1: A read-only counter reports the receive FIFO fill level from 0 to 64 and ignores writes.
// RULE2: An eight-bit write-only register sets the receive trigger threshold from 0 to 64.
// RULE3: A receive request is raised when the fill level rises to reach the trigger threshold.
// RULE4: Two stop and two resume characters are held write-only for sending and for receive compare; here they feed only the receive compare.
// RULE5: The flow character status reads all zeros whenever software flow control is disabled.
// RULE6: Status bit 3 marks that the last sent control character was resume and clears on read.
// RULE7: Status bit 2 marks that the last sent control character was stop and clears on read.
// RULE8: Status bit 1 marks that the last received control character was resume and clears on read.
// RULE9: Status bit 0 marks that the last received control character was stop and clears on read.
// RULE10: After reset the modem status low nibble is zero and the high nibble shows the modem inputs.
// RULE11: Software flow control is off when the four select bits are zero, their reset value.
// RULE12: Reset clears counters, thresholds, characters and status and sets the serial outputs idle.
// RULE13: The four upper bits of the flow character status always read zero.
`timescale 1ns/1ps
`default_nettype none
module uffs_top
   import uffs_pkg::*;
#(
   parameter int unsigned FIFO_DEPTH = UFFS_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [UFFS_AW-1:0] reg_addr,
   input wire logic [UFFS_DW-1:0] reg_wdata,
   output logic [UFFS_DW-1:0] reg_rdata,
   input wire logic rx_push,
   input wire logic rx_pop,
   input wire logic rx_ctl_valid,
   input wire logic [UFFS_DW-1:0] rx_ctl_char,
   input wire logic tx_sent_stop,
   input wire logic tx_sent_resume,
   input wire logic tx_level,
   input wire logic ir_level,
   input wire logic rts_level_n,
   input wire logic dtr_level_n,
   input wire logic [3:0] modem_in,
   output logic [UFFS_DW-1:0] rx_fifo_fill_count,
   output logic rx_trig_req,
   output logic flow_ctl_en,
   output logic ser_tx_out,
   output logic infrared_transmit_out,
   output logic rts_out_n,
   output logic dtr_out_n
);
   initial begin
      if (FIFO_DEPTH < 1 || FIFO_DEPTH > 255) begin
         $error("FIFO_DEPTH must lie between 1 and 255");
      end
   end

   localparam logic [UFFS_DW-1:0] DEPTH_MAX = UFFS_DW'(FIFO_DEPTH);

   logic [UFFS_DW-1:0] rx_fifo_trigger_threshold;
   logic [UFFS_DW-1:0] enhanced_feature_reg;
   logic [3:0] flow_char_event_status;
   logic [UFFS_DW-1:0] modem_status_reg;
   logic [3:0] modem_meta;
   logic [3:0] modem_sync;
   logic modem_seen;
   logic [UFFS_DW-1:0] stop_char_first;
   logic [UFFS_DW-1:0] stop_char_second;
   logic [UFFS_DW-1:0] resume_char_first;
   logic [UFFS_DW-1:0] resume_char_second;
   logic prev_stop_first;
   logic prev_resume_first;
   logic [UFFS_DW-1:0] next_count;
   logic next_flow_en;
   logic wr_char;
   logic [1:0] wr_char_sel;
   logic rd_status;
   logic rd_modem;
   logic rx_stop_hit;
   logic rx_resume_hit;

   // Compares one received character against the enabled characters of a pair.
   function automatic logic fc_hit(input logic [UFFS_DW-1:0] c, input logic [UFFS_DW-1:0] x1,
                                   input logic [UFFS_DW-1:0] x2, input logic use1, input logic use2);
      fc_hit = (use1 && c == x1) || (use2 && c == x2);
   endfunction

   // Register port decode.
   always_comb begin
      wr_char = 1'b0;
      wr_char_sel = UFFS_CHR_STOP1;
      if (reg_wr && reg_addr == UFFS_OFS_STOP1) begin
         wr_char = 1'b1;
         wr_char_sel = UFFS_CHR_STOP1;
      end else if (reg_wr && reg_addr == UFFS_OFS_STOP2) begin
         wr_char = 1'b1;
         wr_char_sel = UFFS_CHR_STOP2;
      end else if (reg_wr && reg_addr == UFFS_OFS_RESUME1) begin
         wr_char = 1'b1;
         wr_char_sel = UFFS_CHR_RESUME1;
      end else if (reg_wr && reg_addr == UFFS_OFS_RESUME2) begin
         wr_char = 1'b1;
         wr_char_sel = UFFS_CHR_RESUME2;
      end
   end

   assign rd_status = reg_rd && reg_addr == UFFS_OFS_FLOW_STATUS;
   assign rd_modem = reg_rd && reg_addr == UFFS_OFS_MODEM;

   uffs_char_bank #(
      .WIDTH(UFFS_DW)
   ) u_chars (
      .clk(clk),
      .rst(rst),
      .wr_en(wr_char),
      .wr_sel(wr_char_sel),
      .wr_data(reg_wdata),
      .stop_char_first(stop_char_first),
      .stop_char_second(stop_char_second),
      .resume_char_first(resume_char_first),
      .resume_char_second(resume_char_second)
   );

   // Fill counter: saturating at both ends so a stray pulse cannot wrap it.
   always_comb begin
      next_count = rx_fifo_fill_count;
      if (rx_push && !rx_pop && rx_fifo_fill_count != DEPTH_MAX) begin
         next_count = rx_fifo_fill_count + 8'h01;
      end else if (rx_pop && !rx_push && rx_fifo_fill_count != UFFS_RST_BYTE) begin
         next_count = rx_fifo_fill_count - 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rx_fifo_fill_count <= UFFS_RST_BYTE; // see RULE12
      end else begin
         rx_fifo_fill_count <= next_count; // see RULE1
      end
   end

   // Out-of-range thresholds are clamped so the request stays reachable.
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_fifo_trigger_threshold <= UFFS_RST_BYTE; // see RULE12
      end else if (reg_wr && reg_addr == UFFS_OFS_RX_TRIG) begin
         rx_fifo_trigger_threshold <= (reg_wdata > DEPTH_MAX) ? DEPTH_MAX : reg_wdata; // see RULE2
      end
   end

   // A zero threshold never fires, since the level can never rise to zero.
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_trig_req <= 1'b0;
      end else begin
         rx_trig_req <= rx_fifo_trigger_threshold != UFFS_RST_BYTE
                        && next_count >= rx_fifo_trigger_threshold; // see RULE3
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         enhanced_feature_reg <= UFFS_RST_BYTE; // see RULE11
      end else if (reg_wr && reg_addr == UFFS_OFS_FEATURE) begin
         enhanced_feature_reg <= reg_wdata;
      end
   end

   assign next_flow_en = enhanced_feature_reg[3:0] != UFFS_FLOW_OFF; // see RULE11

   always_ff @(posedge clk) begin
      if (rst) begin
         flow_ctl_en <= 1'b0;
      end else begin
         flow_ctl_en <= next_flow_en;
      end
   end

   // Receive compare by select mode; single-char modes match only their own character, the mixed modes accept either,
   // while both-pair modes need the first character directly followed by the second.
   always_comb begin
      rx_stop_hit = 1'b0;
      rx_resume_hit = 1'b0;
      case (uffs_rxcmp_t'(enhanced_feature_reg[1:0]))
         UFFS_RXCMP_FIRST: begin
            rx_stop_hit = fc_hit(rx_ctl_char, stop_char_first, stop_char_second, 1'b1, 1'b0);
            rx_resume_hit = fc_hit(rx_ctl_char, resume_char_first, resume_char_second, 1'b1, 1'b0);
         end
         UFFS_RXCMP_SECOND: begin
            rx_stop_hit = fc_hit(rx_ctl_char, stop_char_first, stop_char_second, 1'b0, 1'b1);
            rx_resume_hit = fc_hit(rx_ctl_char, resume_char_first, resume_char_second, 1'b0, 1'b1);
         end
         UFFS_RXCMP_BOTH: begin
            if (enhanced_feature_reg[3] ^ enhanced_feature_reg[2]) begin
               rx_stop_hit = fc_hit(rx_ctl_char, stop_char_first, stop_char_second, 1'b1, 1'b1);
               rx_resume_hit = fc_hit(rx_ctl_char, resume_char_first, resume_char_second, 1'b1, 1'b1);
            end else begin
               rx_stop_hit = prev_stop_first
                             && fc_hit(rx_ctl_char, stop_char_first, stop_char_second, 1'b0, 1'b1);
               rx_resume_hit = prev_resume_first
                               && fc_hit(rx_ctl_char, resume_char_first, resume_char_second, 1'b0, 1'b1);
            end
         end
         default: begin
            rx_stop_hit = 1'b0;
            rx_resume_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prev_stop_first <= 1'b0;
         prev_resume_first <= 1'b0;
      end else if (rx_ctl_valid) begin
         prev_stop_first <= rx_ctl_char == stop_char_first;
         prev_resume_first <= rx_ctl_char == resume_char_first;
      end
   end

   // Only the latest event of each direction stays marked; a new event beats a read in the same cycle.
   always_ff @(posedge clk) begin
      if (rst || !next_flow_en) begin
         flow_char_event_status <= 4'h0; // see RULE5
      end else begin
         if (tx_sent_resume) begin
            flow_char_event_status[UFFS_ST_TX_RESUME] <= 1'b1; // see RULE6
            flow_char_event_status[UFFS_ST_TX_STOP] <= 1'b0;
         end else if (tx_sent_stop) begin
            flow_char_event_status[UFFS_ST_TX_STOP] <= 1'b1; // see RULE7
            flow_char_event_status[UFFS_ST_TX_RESUME] <= 1'b0;
         end else if (rd_status) begin
            flow_char_event_status[UFFS_ST_TX_RESUME] <= 1'b0; // see RULE6
            flow_char_event_status[UFFS_ST_TX_STOP] <= 1'b0; // see RULE7
         end
         if (rx_ctl_valid && rx_resume_hit) begin
            flow_char_event_status[UFFS_ST_RX_RESUME] <= 1'b1; // see RULE8
            flow_char_event_status[UFFS_ST_RX_STOP] <= 1'b0;
         end else if (rx_ctl_valid && rx_stop_hit) begin
            flow_char_event_status[UFFS_ST_RX_STOP] <= 1'b1; // see RULE9
            flow_char_event_status[UFFS_ST_RX_RESUME] <= 1'b0;
         end else if (rd_status) begin
            flow_char_event_status[UFFS_ST_RX_RESUME] <= 1'b0; // see RULE8
            flow_char_event_status[UFFS_ST_RX_STOP] <= 1'b0; // see RULE9
         end
      end
   end

   // The synchroniser runs through reset so the pin levels have settled when reset ends.
   // A reset stage here would show a false change on every pin that is high.
   always_ff @(posedge clk) begin
      modem_meta <= modem_in;
      modem_sync <= modem_meta;
   end

   // The first cycle after reset loads the pin levels without flagging a change.
   always_ff @(posedge clk) begin
      if (rst) begin
         modem_status_reg <= {modem_sync, 4'h0}; // see RULE10
         modem_seen <= 1'b0;
      end else begin
         modem_seen <= 1'b1;
         modem_status_reg[7:4] <= modem_sync; // see RULE10
         if (!modem_seen) begin
            modem_status_reg[3:0] <= 4'h0; // see RULE10
         end else begin
            modem_status_reg[3:0] <= (rd_modem ? 4'h0 : modem_status_reg[3:0])
                                     | (modem_sync ^ modem_status_reg[7:4]);
         end
      end
   end

   // Serial outputs idle until the channel drives them.
   always_ff @(posedge clk) begin
      if (rst) begin
         ser_tx_out <= 1'b1; // see RULE12
         infrared_transmit_out <= 1'b0;
         rts_out_n <= 1'b1;
         dtr_out_n <= 1'b1;
      end else begin
         ser_tx_out <= tx_level;
         infrared_transmit_out <= ir_level;
         rts_out_n <= rts_level_n;
         dtr_out_n <= dtr_level_n;
      end
   end

   // Read data; write-only and unmapped locations read zero.
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= UFFS_RST_BYTE;
      end else if (reg_rd) begin
         if (reg_addr == UFFS_OFS_RX_COUNT) begin
            reg_rdata <= rx_fifo_fill_count; // see RULE1
         end else if (reg_addr == UFFS_OFS_FLOW_STATUS) begin
            reg_rdata <= {4'h0, flow_char_event_status}; // see RULE13
         end else if (reg_addr == UFFS_OFS_FEATURE) begin
            reg_rdata <= enhanced_feature_reg;
         end else if (reg_addr == UFFS_OFS_MODEM) begin
            reg_rdata <= modem_status_reg;
         end else begin
            reg_rdata <= UFFS_RST_BYTE;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_count_max;
      rx_fifo_fill_count <= DEPTH_MAX;
   endproperty
   a_count_max: assert property (p_count_max) else $error("fill count above depth"); // see RULE1

   property p_count_up;
      rx_push && !rx_pop && rx_fifo_fill_count < DEPTH_MAX |=> rx_fifo_fill_count == $past(rx_fifo_fill_count) + 8'h01;
   endproperty
   a_count_up: assert property (p_count_up) else $error("fill count missed a push"); // see RULE1

   property p_trig_max;
      rx_fifo_trigger_threshold <= DEPTH_MAX;
   endproperty
   a_trig_max: assert property (p_trig_max) else $error("threshold above depth"); // see RULE2

   property p_trig_rise;
      rx_fifo_trigger_threshold != 8'h00 && next_count == rx_fifo_trigger_threshold |=> rx_trig_req;
   endproperty
   a_trig_rise: assert property (p_trig_rise) else $error("trigger level reached without request"); // see RULE3

   property p_status_off;
      !next_flow_en |=> flow_char_event_status == 4'h0;
   endproperty
   a_status_off: assert property (p_status_off) else $error("status kept while flow control off"); // see RULE5

   property p_tx_resume;
      tx_sent_resume && next_flow_en |=> flow_char_event_status[3] && !flow_char_event_status[2];
   endproperty
   a_tx_resume: assert property (p_tx_resume) else $error("sent resume not marked"); // see RULE6

   property p_tx_stop;
      tx_sent_stop && !tx_sent_resume && next_flow_en |=> flow_char_event_status[2];
   endproperty
   a_tx_stop: assert property (p_tx_stop) else $error("sent stop not marked"); // see RULE7

   property p_rx_read_clear;
      rd_status && !rx_ctl_valid |=> flow_char_event_status[1:0] == 2'b00;
   endproperty
   a_rx_read_clear: assert property (p_rx_read_clear) else $error("receive marks survived a read"); // see RULE8

   property p_rx_stop;
      rx_ctl_valid && rx_stop_hit && !rx_resume_hit && next_flow_en |=> flow_char_event_status[0];
   endproperty
   a_rx_stop: assert property (p_rx_stop) else $error("received stop not marked"); // see RULE9

   property p_reserved_zero;
      $past(rd_status) |-> reg_rdata[7:4] == 4'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bits set"); // see RULE13
endmodule
`default_nettype wire

// ===== tb/uffs_peer.sv
// Purpose: Far side of the channel: receive FIFO traffic and flow control characters in both directions.
// Assumes: Tasks are entered just after a rising edge and return just after one.
// Notes: Each task leaves one idle cycle, so back to back calls never retoggle a line in one time step.
`timescale 1ns/1ps
`default_nettype none
module uffs_peer (
   input wire logic clk,
   output logic rx_push,
   output logic rx_pop,
   output logic rx_ctl_valid,
   output logic [7:0] rx_ctl_char,
   output logic tx_sent_stop,
   output logic tx_sent_resume
);
   initial begin
      rx_push = 1'b0;
      rx_pop = 1'b0;
      rx_ctl_valid = 1'b0;
      rx_ctl_char = 8'h00;
      tx_sent_stop = 1'b0;
      tx_sent_resume = 1'b0;
   end
   task automatic fifo(input logic push, input logic pop, input int n);
      rx_push = push;
      rx_pop = pop;
      repeat (n) @(posedge clk);
      #1;
      rx_push = 1'b0;
      rx_pop = 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic ctl(input logic [7:0] ch);
      rx_ctl_valid = 1'b1;
      rx_ctl_char = ch;
      @(posedge clk);
      #1;
      rx_ctl_valid = 1'b0;
      // A released character line must not keep showing a value that could match.
      rx_ctl_char = ~ch;
      @(posedge clk);
      #1;
   endtask
   task automatic sent(input logic stop, input logic resume);
      tx_sent_stop = stop;
      tx_sent_resume = resume;
      @(posedge clk);
      #1;
      tx_sent_stop = 1'b0;
      tx_sent_resume = 1'b0;
      @(posedge clk);
      #1;
   endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: Self-checking bench for the receive level, trigger and flow character block.
// Assumes: Inputs change 1 ns after the rising edge; read data are taken at that point.
// Notes: Flow status cases run from a table; reset, fill limits and pairing are written by hand.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import uffs_pkg::*;
   typedef struct packed {logic [3:0] f; logic v; logic [7:0] c; logic s; logic r; logic [7:0] e;} uffs_row_t;
   logic clk = 1'b0;
   logic rst, reg_wr, reg_rd, tx_level, ir_level, rts_level_n, dtr_level_n;
   logic [UFFS_AW-1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rx_ctl_char, rx_fifo_fill_count;
   logic [3:0] modem_in;
   logic rx_push, rx_pop, rx_ctl_valid, tx_sent_stop, tx_sent_resume;
   logic rx_trig_req, flow_ctl_en, ser_tx_out, infrared_transmit_out, rts_out_n, dtr_out_n;
   int failures = 0;
   int checks = 0;
   uffs_row_t rows [13] = '{'{4'h0, 1'b1, 8'h13, 1'b1, 1'b0, 8'h00}, '{4'ha, 1'b1, 8'h13, 1'b0, 1'b0, 8'h01},
      '{4'ha, 1'b1, 8'h11, 1'b0, 1'b0, 8'h02}, '{4'ha, 1'b1, 8'h93, 1'b0, 1'b0, 8'h00},
      '{4'h9, 1'b1, 8'h93, 1'b0, 1'b0, 8'h01}, '{4'h9, 1'b1, 8'h91, 1'b0, 1'b0, 8'h02},
      '{4'ha, 1'b0, 8'h00, 1'b1, 1'b0, 8'h04}, '{4'ha, 1'b0, 8'h00, 1'b0, 1'b1, 8'h08},
      '{4'ha, 1'b1, 8'h13, 1'b0, 1'b1, 8'h09}, '{4'ha, 1'b1, 8'h55, 1'b1, 1'b0, 8'h04},
      '{4'he, 1'b1, 8'h11, 1'b0, 1'b0, 8'h02}, '{4'hb, 1'b1, 8'h93, 1'b0, 1'b0, 8'h01},
      '{4'h7, 1'b1, 8'h91, 1'b0, 1'b0, 8'h02}};
   always #2 clk = ~clk;
   uffs_top #(.FIFO_DEPTH(UFFS_FIFO_DEPTH)) i_uffs_top (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_push(rx_push), .rx_pop(rx_pop),
      .rx_ctl_valid(rx_ctl_valid), .rx_ctl_char(rx_ctl_char), .tx_sent_stop(tx_sent_stop),
      .tx_sent_resume(tx_sent_resume), .tx_level(tx_level), .ir_level(ir_level), .rts_level_n(rts_level_n),
      .dtr_level_n(dtr_level_n), .modem_in(modem_in), .rx_fifo_fill_count(rx_fifo_fill_count),
      .rx_trig_req(rx_trig_req), .flow_ctl_en(flow_ctl_en), .ser_tx_out(ser_tx_out),
      .infrared_transmit_out(infrared_transmit_out), .rts_out_n(rts_out_n), .dtr_out_n(dtr_out_n));
   uffs_peer i_uffs_peer (.clk(clk), .rx_push(rx_push), .rx_pop(rx_pop), .rx_ctl_valid(rx_ctl_valid),
      .rx_ctl_char(rx_ctl_char), .tx_sent_stop(tx_sent_stop), .tx_sent_resume(tx_sent_resume));
   task automatic test_done();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [7:0] e, input string nm);
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      chk8(nm, e, reg_rdata);
      @(posedge clk);
      #1;
   endtask
   task automatic idle_outs(input logic tx, input logic ir, input logic rts, input logic dtr);
      chk1("ser_tx_out", tx, ser_tx_out);
      chk1("infrared_transmit_out", ir, infrared_transmit_out);
      chk1("rts_out_n", rts, rts_out_n);
      chk1("dtr_out_n", dtr, dtr_out_n);
   endtask
   task automatic fill(input logic push, input logic pop, input int n, input logic [7:0] e, input logic q);
      i_uffs_peer.fifo(push, pop, n);
      chk8("rx_fifo_fill_count", e, rx_fifo_fill_count);
      chk1("rx_trig_req", q, rx_trig_req);
   endtask
   initial begin
      // Generous bound: the sequence needs only about five hundred cycles.
      #200000;
      failures++;
      test_done();
   end
   initial begin
      rst = 1'b1;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {tx_level, ir_level, rts_level_n, dtr_level_n} = 4'b0100;
      modem_in = 4'ha;
      repeat (20) @(posedge clk);
      #1;
      idle_outs(1'b1, 1'b0, 1'b1, 1'b1);
      fill(1'b0, 1'b0, 0, 8'h00, 1'b0);
      chk1("flow_ctl_en", 1'b0, flow_ctl_en);
      rst = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      idle_outs(1'b0, 1'b1, 1'b0, 1'b0);
      rdchk(UFFS_OFS_MODEM, 8'ha0, "modem status");
      rdchk(UFFS_OFS_FEATURE, 8'h00, "feature");
      $display("test reset done");
      for (int a = 0; a < 16; a++) begin
         if (a != 7) wr(a[3:0], 8'hff);
         if (a != 7) rdchk(a[3:0], (a == 8) ? 8'ha0 : 8'h00, "register map");
      end
      $display("test register map done");
      wr(UFFS_OFS_STOP1, 8'h13);
      wr(UFFS_OFS_STOP2, 8'h93);
      wr(UFFS_OFS_RESUME1, 8'h11);
      wr(UFFS_OFS_RESUME2, 8'h91);
      foreach (rows[i]) begin
         wr(UFFS_OFS_FEATURE, 8'h00);
         wr(UFFS_OFS_FEATURE, {4'h0, rows[i].f});
         chk1("flow_ctl_en", rows[i].f != 4'h0, flow_ctl_en);
         if (rows[i].v) i_uffs_peer.ctl(rows[i].c);
         if (rows[i].s | rows[i].r) i_uffs_peer.sent(rows[i].s, rows[i].r);
         rdchk(UFFS_OFS_FLOW_STATUS, rows[i].e, "flow status");
         rdchk(UFFS_OFS_FLOW_STATUS, 8'h00, "status after read");
      end
      rdchk(UFFS_OFS_FEATURE, 8'h07, "feature");
      $display("test flow table done");
      wr(UFFS_OFS_RX_TRIG, 8'h03);
      fill(1'b1, 1'b0, 2, 8'h02, 1'b0);
      fill(1'b1, 1'b0, 1, 8'h03, 1'b1);
      rdchk(UFFS_OFS_RX_COUNT, 8'h03, "fill count");
      fill(1'b1, 1'b1, 4, 8'h03, 1'b1);
      fill(1'b1, 1'b0, 70, 8'h40, 1'b1);
      // A threshold above the depth is held at the depth, so a full FIFO still requests.
      wr(UFFS_OFS_RX_TRIG, 8'h50);
      chk1("rx_trig_req", 1'b1, rx_trig_req);
      fill(1'b0, 1'b1, 64, 8'h00, 1'b0);
      fill(1'b0, 1'b1, 2, 8'h00, 1'b0);
      wr(UFFS_OFS_RX_TRIG, 8'h00);
      fill(1'b1, 1'b0, 1, 8'h01, 1'b0);
      $display("test fill and trigger done");
      wr(UFFS_OFS_FEATURE, 8'h00);
      wr(UFFS_OFS_FEATURE, 8'h03);
      i_uffs_peer.ctl(8'h13);
      i_uffs_peer.ctl(8'h93);
      rdchk(UFFS_OFS_FLOW_STATUS, 8'h01, "pair stop");
      i_uffs_peer.ctl(8'h11);
      rdchk(UFFS_OFS_FLOW_STATUS, 8'h00, "half pair");
      i_uffs_peer.ctl(8'h91);
      rdchk(UFFS_OFS_FLOW_STATUS, 8'h02, "pair resume");
      wr(UFFS_OFS_FEATURE, 8'h00);
      wr(UFFS_OFS_FEATURE, 8'h0a);
      i_uffs_peer.ctl(8'h13);
      i_uffs_peer.ctl(8'h11);
      rdchk(UFFS_OFS_FLOW_STATUS, 8'h02, "last received");
      i_uffs_peer.ctl(8'h13);
      wr(UFFS_OFS_FEATURE, 8'h00);
      rdchk(UFFS_OFS_FLOW_STATUS, 8'h00, "disabled status");
      $display("test pairing and disable done");
      {tx_level, ir_level, rts_level_n, dtr_level_n} = 4'b1011;
      modem_in = 4'h5;
      repeat (4) @(posedge clk);
      #1;
      idle_outs(1'b1, 1'b0, 1'b1, 1'b1);
      rdchk(UFFS_OFS_MODEM, 8'h5f, "modem change");
      rdchk(UFFS_OFS_MODEM, 8'h50, "modem cleared");
      {tx_level, ir_level, rts_level_n, dtr_level_n} = 4'b0100;
      $display("test pins and modem done");
      wr(UFFS_OFS_FEATURE, 8'h0a);
      i_uffs_peer.fifo(1'b1, 1'b0, 5);
      rst = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      idle_outs(1'b1, 1'b0, 1'b1, 1'b1);
      rst = 1'b0;
      fill(1'b0, 1'b0, 0, 8'h00, 1'b0);
      chk1("flow_ctl_en", 1'b0, flow_ctl_en);
      rdchk(UFFS_OFS_MODEM, 8'h50, "modem after reset");
      wr(UFFS_OFS_FEATURE, 8'h0a);
      i_uffs_peer.ctl(8'h13);
      rdchk(UFFS_OFS_FLOW_STATUS, 8'h00, "cleared characters");
      $display("test second reset done");
      test_done();
   end
endmodule
`default_nettype wire
